/* rtl/ram_cell_pkg.sv */
// Shared constants and types of the edge-triggered lookup-table RAM cell.
// Assumes one system clock; all users import the whole package.
`default_nettype none

package ram_cell_pkg;

	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int ADDR_W = 4;
	localparam int HALF_WORDS = 16;
	localparam int CELL_BITS = 32;
	localparam int SYNC_STAGES = 3;
	localparam int TABLE_BITS = 8;

	// Bit positions inside one delayed input sample.
	localparam int POS_ADDR = 0;
	localparam int POS_D0 = 4;
	localparam int POS_D1 = 5;
	localparam int POS_WE = 6;
	localparam int SAMPLE_W = 7;

	// ****************************************************************
	// Reset and power-up values
	// ****************************************************************
	localparam logic [31:0] INIT_ZERO = 32'h0000_0000;
	localparam logic RESET_FF = 1'h0;

	// Source of a cell flip-flop; Gray order along F, G, H, D0.
	typedef enum logic [1:0] {
		SRC_F = 2'h0,
		SRC_G = 2'h1,
		SRC_H = 2'h3,
		SRC_D0 = 2'h2
	} ff_src_t;

	typedef logic [SAMPLE_W-1:0] sample_t;

endpackage : ram_cell_pkg

`default_nettype wire

/* rtl/cell_out_if.sv */
// Carrier between the RAM core and the cell's output stage.
// Assumes both ends run on the same system clock.
`default_nettype none

interface cell_out_if;
	import ram_cell_pkg::*;
	logic f_out;
	logic g_out;
	logic d0;
	logic d1;
	logic [TABLE_BITS-1:0] h_table;
	ff_src_t src_x;
	ff_src_t src_y;
	logic ff_strobe;

	modport ram_side (
		output f_out,
		output g_out,
		output d0,
		output d1,
		output h_table,
		output src_x,
		output src_y,
		output ff_strobe
	);

	modport stage_side (
		input f_out,
		input g_out,
		input d0,
		input d1,
		input h_table,
		input src_x,
		input src_y,
		input ff_strobe
	);
endinterface : cell_out_if

`default_nettype wire

/* rtl/cell_output_stage.sv */
// Third function generator and the two cell flip-flops.
// Assumes the strobe is a one-cycle pulse on the system clock.
`default_nettype none

module cell_output_stage (
	input wire logic clock,
	input wire logic rst,
	cell_out_if.stage_side link,
	output logic h_out,
	output logic ff_x_q,
	output logic ff_y_q
);
	import ram_cell_pkg::*;

	typedef struct packed {
		logic ff_x;
		logic ff_y;
	} stage_t;

	stage_t st;
	stage_t next_st;

	// Source multiplexer shared by both flip-flop selectors.
	function automatic logic pick(input ff_src_t src, input logic f, input logic g,
			input logic h, input logic d0);
		case (src)
			SRC_F: pick = f;
			SRC_G: pick = g;
			SRC_H: pick = h;
			SRC_D0: pick = d0;
			default: pick = f;
		endcase
	endfunction : pick

	// H combines both table outputs with the second data pin.
	assign h_out = link.h_table[{link.d1, link.g_out, link.f_out}];

	// Flip-flops load only on the chosen clock edge; reset clears them, not the RAM.
	always_comb begin
		next_st = st;
		if (link.ff_strobe) begin
			next_st.ff_x = pick(link.src_x, link.f_out, link.g_out, h_out, link.d0);
			next_st.ff_y = pick(link.src_y, link.f_out, link.g_out, h_out, link.d0);
		end
		if (rst) begin
			next_st.ff_x = RESET_FF;
			next_st.ff_y = RESET_FF;
		end
	end

	always_ff @(posedge clock) begin
		st <= next_st;
	end

	assign ff_x_q = st.ff_x;
	assign ff_y_q = st.ff_y;

	chk_ff_x_capture: assert property (@(posedge clock) disable iff (rst)
		link.ff_strobe && link.src_x == SRC_F |=> ff_x_q == $past(link.f_out))
		else $error("ff_x did not take F on its strobe");

	chk_ff_y_hold: assert property (@(posedge clock) disable iff (rst)
		!link.ff_strobe |=> $stable(ff_y_q))
		else $error("ff_y changed without a strobe");

endmodule : cell_output_stage

`default_nettype wire

/* rtl/lut_edge_triggered_sp_ram.sv */
// Single-port edge-triggered RAM cell built from two 16-bit lookup tables.
// Assumes user logic on the system clock drives address, data and enable;
// the write clock is asynchronous and is sampled by three flip-flops.
`default_nettype none

module lut_edge_triggered_sp_ram #(
	parameter logic [31:0] INIT = ram_cell_pkg::INIT_ZERO
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic configure,
	input wire logic write_clock,
	input wire logic write_enable,
	input wire logic [ram_cell_pkg::ADDR_W-1:0] addr,
	input wire logic data_pin_zero,
	input wire logic data_pin_one,
	input wire logic mode_32x1,
	input wire logic write_on_falling,
	input wire logic ff_opposite_edge,
	input wire logic [ram_cell_pkg::TABLE_BITS-1:0] h_table,
	input wire ram_cell_pkg::ff_src_t ff_x_src,
	input wire ram_cell_pkg::ff_src_t ff_y_src,
	output logic [1:0] single_port_out,
	output logic h_out,
	output logic ff_x_q,
	output logic ff_y_q
);
	import ram_cell_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************

	typedef struct packed {
		logic [CELL_BITS-1:0] ram;
		logic [SYNC_STAGES-1:0] wsync;
		logic wclk_level;
		sample_t in_d1;
		sample_t in_d2;
		sample_t cap;
		logic write_pulse;
	} core_t;

	// The RAM word is loaded at power-up, as configuration would do.
	localparam core_t POWER_UP = '{ram: INIT, default: '0};

	core_t st = POWER_UP;
	core_t next_st;

	logic stable;
	logic rise;
	logic fall;
	logic active_edge;
	logic other_edge;
	logic [ADDR_W:0] read_idx;

	cell_out_if link ();

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Index of a table bit: the upper table starts at HALF_WORDS.
	function automatic logic [ADDR_W:0] cell_index(input logic upper,
			input logic [ADDR_W-1:0] a);
		cell_index = {upper, a};
	endfunction : cell_index

	// ****************************************************************
	// Write clock sampling and edge selection
	// ****************************************************************

	// A level counts only once the second and third stages agree,
	// which filters a lone metastable sample of the first stage.
	assign stable = st.wsync[1] == st.wsync[2];
	assign rise = stable && st.wsync[2] && !st.wclk_level;
	assign fall = stable && !st.wsync[2] && st.wclk_level;

	// One polarity bit serves both tables, so both write on the same edge.
	assign active_edge = write_on_falling ? fall : rise;
	assign other_edge = write_on_falling ? rise : fall;

	// ****************************************************************
	// Next state
	// ****************************************************************

	// Inputs are delayed two cycles so they line up with the sampled clock;
	// the user must hold them steady for a few cycles around the edge.
	always_comb begin
		next_st = st;
		next_st.wsync = {st.wsync[SYNC_STAGES-2:0], write_clock};
		if (stable) begin
			next_st.wclk_level = st.wsync[2];
		end
		next_st.in_d1 = {write_enable, data_pin_one, data_pin_zero, addr};
		next_st.in_d2 = st.in_d1;
		next_st.write_pulse = 1'b0;
		// Capture all three together; enable only gates the pulse.
		if (active_edge) begin
			next_st.cap = st.in_d2;
			next_st.write_pulse = st.in_d2[POS_WE];
		end
		// The write itself lands one cycle after the capture.
		if (st.write_pulse) begin
			if (mode_32x1) begin
				next_st.ram[cell_index(st.cap[POS_D1], st.cap[POS_ADDR +: ADDR_W])] =
					st.cap[POS_D0];
			end else begin
				next_st.ram[cell_index(1'b0, st.cap[POS_ADDR +: ADDR_W])] = st.cap[POS_D0];
				next_st.ram[cell_index(1'b1, st.cap[POS_ADDR +: ADDR_W])] = st.cap[POS_D1];
			end
		end
		// Reset clears control state but keeps the stored words. Taking the
		// present clock level avoids a false edge right after release.
		if (rst) begin
			next_st = POWER_UP;
			next_st.ram = st.ram;
			next_st.wsync = {st.wsync[SYNC_STAGES-2:0], write_clock};
			next_st.wclk_level = st.wsync[2];
		end
		// Configuration is the only path that reloads the initial contents.
		if (configure) begin
			next_st.ram = INIT;
		end
	end

	always_ff @(posedge clock) begin
		st <= next_st;
	end

	// ****************************************************************
	// Read path and output stage
	// ****************************************************************

	// In 32x1 the fifth address bit comes live from pin one.
	assign read_idx = cell_index(mode_32x1 && data_pin_one, addr);

	// Reads need no clock, so a finished write shows at once.
	always_comb begin
		single_port_out[0] = st.ram[read_idx];
		single_port_out[1] = st.ram[cell_index(1'b1, addr)];
	end

	// The cell flip-flops see the same outputs the user sees.
	assign link.f_out = single_port_out[0];
	assign link.g_out = single_port_out[1];
	assign link.d0 = data_pin_zero;
	assign link.d1 = data_pin_one;
	assign link.h_table = h_table;
	assign link.src_x = ff_x_src;
	assign link.src_y = ff_y_src;
	assign link.ff_strobe = ff_opposite_edge ? other_edge : active_edge;

	cell_output_stage u_stage (
		.clock(clock),
		.rst(rst),
		.link(link.stage_side),
		.h_out(h_out),
		.ff_x_q(ff_x_q),
		.ff_y_q(ff_y_q)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************

	sequence edge_with_enable;
		active_edge && st.in_d2[POS_WE];
	endsequence

	sequence edge_without_enable;
		active_edge && !st.in_d2[POS_WE];
	endsequence

	sequence pulse_in_16x2;
		st.write_pulse && !mode_32x1 && !configure && !rst;
	endsequence

	sequence pulse_in_upper_half;
		st.write_pulse && mode_32x1 && st.cap[POS_D1] && !configure && !rst;
	endsequence

	chk_write_needs_pulse: assert property (@(posedge clock) disable iff (rst)
		!$past(configure) && !$past(st.write_pulse) |-> st.ram == $past(st.ram))
		else $error("RAM changed without a write pulse");

	chk_enable_gives_pulse: assert property (@(posedge clock) disable iff (rst)
		edge_with_enable |=> st.write_pulse ##1 !st.write_pulse)
		else $error("enabled edge did not give one write pulse");

	chk_no_enable_no_write: assert property (@(posedge clock) disable iff (rst)
		edge_without_enable |=> !st.write_pulse)
		else $error("write pulse without enable");

	chk_edge_polarity: assert property (@(posedge clock) disable iff (rst)
		(rise && !write_on_falling) || (fall && write_on_falling) |-> active_edge)
		else $error("active edge does not follow polarity");

	chk_both_tables: assert property (@(posedge clock) disable iff (rst)
		pulse_in_16x2 |=> st.ram[cell_index(1'b0, $past(st.cap[3:0]))] == $past(st.cap[POS_D0])
			&& st.ram[cell_index(1'b1, $past(st.cap[3:0]))] == $past(st.cap[POS_D1]))
		else $error("16x2 write missed a table");

	chk_upper_half: assert property (@(posedge clock) disable iff (rst)
		pulse_in_upper_half |=> st.ram[HALF_WORDS + $past(st.cap[3:0])] == $past(st.cap[POS_D0]))
		else $error("32x1 upper-half write went astray");

	chk_reset_keeps_ram: assert property (@(posedge clock) disable iff (configure)
		rst |=> st.ram == $past(st.ram))
		else $error("reset disturbed RAM contents");

	chk_config_load: assert property (@(posedge clock) disable iff (rst)
		configure |=> st.ram == INIT)
		else $error("configuration did not load initial contents");

	chk_read_follows: assert property (@(posedge clock) disable iff (rst)
		st.write_pulse && !mode_32x1 && !configure ##1 addr == $past(st.cap[3:0])
			|-> single_port_out[0] == $past(st.cap[POS_D0]))
		else $error("read did not show the finished write");

	// Table G must show its own finished write, just as table F does.
	chk_read_table_g: assert property (@(posedge clock) disable iff (rst)
		st.write_pulse && !mode_32x1 && !configure ##1 addr == $past(st.cap[3:0])
			|-> single_port_out[1] == $past(st.cap[POS_D1]))
		else $error("read did not show the finished write of table G");

	// In 32x1 the read picks the half from pin one, as the write did.
	chk_read_32x1: assert property (@(posedge clock) disable iff (rst)
		st.write_pulse && mode_32x1 && !configure ##1 addr == $past(st.cap[3:0])
			&& data_pin_one == $past(st.cap[POS_D1]) |-> single_port_out[0] == $past(st.cap[POS_D0]))
		else $error("32x1 read did not show the finished write");

	// ****************************************************************
	// Checks of the write pulse and the captured sample
	// ****************************************************************

	sequence pulse_in_lower_half;
		st.write_pulse && mode_32x1 && !st.cap[POS_D1] && !configure && !rst;
	endsequence

	// A pulse lasts one cycle and only ever follows an enabled active edge.
	chk_pulse_one_cycle: assert property (@(posedge clock) disable iff (rst)
		st.write_pulse |=> !st.write_pulse)
		else $error("write pulse lasted more than one cycle");

	chk_pulse_needs_edge: assert property (@(posedge clock) disable iff (rst)
		st.write_pulse |-> $past(active_edge) && $past(st.in_d2[POS_WE]))
		else $error("write pulse without an enabled active edge");

	// Address, data and enable are taken as one sample and then held.
	chk_capture_together: assert property (@(posedge clock) disable iff (rst)
		active_edge |=> st.cap == $past(st.in_d2))
		else $error("active edge did not capture the delayed sample");

	chk_cap_holds: assert property (@(posedge clock) disable iff (rst)
		!active_edge |=> $stable(st.cap))
		else $error("captured sample changed without an active edge");

	// A refused edge leaves every word as it was.
	chk_refused_keeps: assert property (@(posedge clock) disable iff (rst)
		edge_without_enable ##1 !configure |=> st.ram == $past(st.ram))
		else $error("edge without enable changed the RAM");

	// In 32x1 a lower-half write lands there, and an upper-half write spares the lower half.
	chk_lower_half: assert property (@(posedge clock) disable iff (rst)
		pulse_in_lower_half |=> st.ram[cell_index(1'b0, $past(st.cap[3:0]))] == $past(st.cap[POS_D0]))
		else $error("32x1 lower-half write went astray");

	chk_other_half_kept: assert property (@(posedge clock) disable iff (rst)
		pulse_in_upper_half |=> st.ram[cell_index(1'b0, $past(st.cap[3:0]))]
			== $past(st.ram[cell_index(1'b0, st.cap[3:0])]))
		else $error("32x1 upper-half write touched the lower half");

	// ****************************************************************
	// Checks of the write clock edges and of reset
	// ****************************************************************

	// After an active edge the tracked level is the one that edge leads to.
	chk_level_tracks: assert property (@(posedge clock) disable iff (rst)
		active_edge |=> st.wclk_level == !$past(write_on_falling))
		else $error("tracked write clock level does not follow the active edge");

	// A level counts only when both late stages agree, so no edge fires twice.
	chk_level_hold: assert property (@(posedge clock) disable iff (rst)
		!stable |=> st.wclk_level == $past(st.wclk_level))
		else $error("tracked level moved while the stages disagreed");

	chk_one_edge_phase: assert property (@(posedge clock) disable iff (rst)
		active_edge |=> !active_edge)
		else $error("active edge seen in two cycles in a row");

	// The inactive edge may strobe the flops but never writes.
	chk_wrong_edge_ignored: assert property (@(posedge clock) disable iff (rst)
		other_edge |=> !st.write_pulse)
		else $error("inactive write clock edge gave a write pulse");

	// Reset drops a pending write, so reset can never change a word.
	chk_reset_no_pulse: assert property (@(posedge clock)
		rst |=> !st.write_pulse)
		else $error("write pulse survived reset");

endmodule : lut_edge_triggered_sp_ram

`default_nettype wire

/* sim/fabric_user.sv */
// Model of the fabric user logic that presents words and toggles the write clock.
// Assumes the bench's system clock; the polarity input changes only between writes.
`default_nettype none

module fabric_user (
	input wire logic clock,
	input wire logic write_on_falling,
	output logic write_clock,
	output logic write_enable,
	output logic [ram_cell_pkg::ADDR_W-1:0] addr,
	output logic data_pin_zero,
	output logic data_pin_one
);
	timeunit 1ns;
	timeprecision 100ps;
	import ram_cell_pkg::*;

	// ****************************************************************
	// Drivers
	// ****************************************************************
	// Lines start idle with the write clock at its inactive level.
	initial begin
		write_clock = 1'b0;
		write_enable = 1'b0;
		addr = '0;
		data_pin_zero = 1'b0;
		data_pin_one = 1'b0;
	end

	// Inputs always change one nanosecond after a system clock edge.
	task automatic present(input logic [ADDR_W-1:0] a, input logic d0, input logic d1, input logic we);
		@(posedge clock);
		#1;
		addr = a;
		data_pin_zero = d0;
		data_pin_one = d1;
		write_enable = we;
	endtask : present

	// Returns the write clock to the idle level of the chosen polarity.
	task automatic park();
		@(posedge clock);
		#1 write_clock = write_on_falling;
		repeat (6) @(posedge clock);
	endtask : park

	// One write; the active phase lasts a few cycles, far below the damage limit.
	task automatic write_word(input logic [ADDR_W-1:0] a, input logic d0, input logic d1, input logic we);
		present(a, d0, d1, we);
		repeat (4) @(posedge clock);
		#1 write_clock = ~write_on_falling;
		repeat (6) @(posedge clock);
		// Hold has run out, so the lines show the inverse rather than stale data.
		#1;
		data_pin_zero = ~d0;
		data_pin_one = ~d1;
		write_enable = ~we;
		repeat (2) @(posedge clock);
		#1 write_clock = write_on_falling;
		repeat (6) @(posedge clock);
	endtask : write_word
endmodule : fabric_user

`default_nettype wire

/* sim/lut_edge_triggered_sp_ram_tb_top.sv */
// Self-checking bench of the edge-triggered lookup-table RAM cell.
// Assumes the fabric_user model drives the write side of the cell.
`default_nettype none

module lut_edge_triggered_sp_ram_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import ram_cell_pkg::*;

	logic clock = 1'b0;
	logic rst = 1'b1;
	logic configure = 1'b0;
	logic mode_32x1 = 1'b0;
	logic write_on_falling = 1'b0;
	logic ff_opposite_edge = 1'b0;
	logic [TABLE_BITS-1:0] h_table = '0;
	ff_src_t ff_x_src = SRC_F;
	ff_src_t ff_y_src = SRC_D0;
	logic write_clock, write_enable, data_pin_zero, data_pin_one, h_out, ff_x_q, ff_y_q;
	logic [ADDR_W-1:0] addr;
	logic [1:0] single_port_out;
	int num_errors = 0;
	int num_checks = 0;

	// The 200 MHz system clock.
	initial begin
		forever #2.5 clock = ~clock;
	end

	fabric_user user (.clock(clock), .write_on_falling(write_on_falling), .write_clock(write_clock),
		.write_enable(write_enable), .addr(addr), .data_pin_zero(data_pin_zero), .data_pin_one(data_pin_one));

	lut_edge_triggered_sp_ram DUT (.clock(clock), .rst(rst), .configure(configure), .write_clock(write_clock),
		.write_enable(write_enable), .addr(addr), .data_pin_zero(data_pin_zero), .data_pin_one(data_pin_one),
		.mode_32x1(mode_32x1), .write_on_falling(write_on_falling), .ff_opposite_edge(ff_opposite_edge),
		.h_table(h_table), .ff_x_src(ff_x_src), .ff_y_src(ff_y_src), .single_port_out(single_port_out),
		.h_out(h_out), .ff_x_q(ff_x_q), .ff_y_q(ff_y_q));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic check(input string name, input logic [1:0] exp, input logic [1:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check

	// Reads are combinational, so a sample two nanoseconds later is settled.
	task automatic read(input logic [ADDR_W-1:0] a, input logic d1, input logic [1:0] exp);
		user.present(a, 1'b0, d1, 1'b0);
		#2 check("single_port_out", exp, single_port_out);
	endtask : read

	task automatic print_verdict();
		$display("checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_power_up();
		for (int i = 0; i < HALF_WORDS; i++) begin
			read(4'(i), 1'b0, 2'h0);
		end
	endtask : t_power_up

	// Back-to-back writes, then a refused one with enable low.
	task automatic t_write();
		user.write_word(4'h3, 1'b1, 1'b0, 1'b1);
		user.write_word(4'h4, 1'b0, 1'b1, 1'b1);
		user.write_word(4'h5, 1'b1, 1'b1, 1'b1);
		user.write_word(4'h4, 1'b1, 1'b0, 1'b0);
		read(4'h3, 1'b0, 2'h1);
		read(4'h4, 1'b0, 2'h2);
		read(4'h5, 1'b0, 2'h3);
		read(4'h2, 1'b0, 2'h0);
	endtask : t_write

	// Data is inverted before the rising return edge, which must be ignored.
	task automatic t_falling();
		@(posedge clock);
		#1 write_on_falling = 1'b1;
		user.park();
		user.write_word(4'h7, 1'b1, 1'b1, 1'b1);
		read(4'h7, 1'b0, 2'h3);
		@(posedge clock);
		#1 write_on_falling = 1'b0;
		user.park();
	endtask : t_falling

	// Same edge catches the old word; opposite edge catches the new one.
	task automatic t_flops();
		user.write_word(4'h8, 1'b1, 1'b0, 1'b1);
		#1 check("flops same edge", 2'h1, {ff_x_q, ff_y_q});
		ff_opposite_edge = 1'b1;
		user.write_word(4'h8, 1'b0, 1'b0, 1'b1);
		#1 check("flops opposite edge", 2'h1, {ff_x_q, ff_y_q});
		ff_opposite_edge = 1'b0;
		// Word 5 holds ones in both tables; rewriting it keeps them.
		ff_x_src = SRC_G;
		ff_y_src = SRC_H;
		h_table = 8'h80;
		user.write_word(4'h5, 1'b1, 1'b1, 1'b1);
		#1 check("flops from G and H", 2'h3, {ff_x_q, ff_y_q});
	endtask : t_flops

	// Word 5 holds ones in both tables, so H sees index {pin one, 1, 1}.
	task automatic t_h_func();
		for (int d = 0; d < 2; d++) begin
			@(posedge clock);
			#1 h_table = 8'h08 << (4 * d);
			read(4'h5, 1'(d), 2'h3);
			check("h_out", 2'h1, {1'b0, h_out});
			@(posedge clock);
			#1 h_table = ~h_table;
			#1 check("h_out", 2'h0, {1'b0, h_out});
		end
	endtask : t_h_func

	// Pin one picks the half both for the write and for the read.
	task automatic t_32x1();
		@(posedge clock);
		#1 mode_32x1 = 1'b1;
		user.write_word(4'h9, 1'b1, 1'b1, 1'b1);
		user.present(4'h9, 1'b0, 1'b1, 1'b0);
		#2 check("upper half", 2'h1, {1'b0, single_port_out[0]});
		user.present(4'h9, 1'b0, 1'b0, 1'b0);
		#2 check("lower half", 2'h0, {1'b0, single_port_out[0]});
		// A lower-half write must not clear the upper bit as a 16x2 write would.
		user.write_word(4'h9, 1'b1, 1'b0, 1'b1);
		user.present(4'h9, 1'b0, 1'b0, 1'b0);
		#2 check("lower half written", 2'h1, {1'b0, single_port_out[0]});
		user.present(4'h9, 1'b0, 1'b1, 1'b0);
		#2 check("upper half kept", 2'h1, {1'b0, single_port_out[0]});
		@(posedge clock);
		#1 mode_32x1 = 1'b0;
	endtask : t_32x1

	task automatic t_reset();
		@(posedge clock);
		#1 rst = 1'b1;
		repeat (3) @(posedge clock);
		#1 rst = 1'b0;
		check("flops after reset", 2'h0, {ff_x_q, ff_y_q});
		read(4'h5, 1'b0, 2'h3);
	endtask : t_reset

	task automatic t_configure();
		@(posedge clock);
		#1 configure = 1'b1;
		@(posedge clock);
		#1 configure = 1'b0;
		read(4'h5, 1'b0, 2'h0);
		read(4'h3, 1'b0, 2'h0);
	endtask : t_configure

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		repeat (10) @(posedge clock);
		#1 rst = 1'b0;
		t_power_up();
		t_write();
		t_falling();
		t_flops();
		t_h_func();
		t_32x1();
		t_reset();
		t_configure();
		print_verdict();
	end

	// The run needs under 2000 cycles; this limit leaves ample margin.
	initial begin
		#100us;
		num_errors++;
		$display("unexpected timeout: expected end of tests, seen none");
		print_verdict();
	end
endmodule : lut_edge_triggered_sp_ram_tb_top

`default_nettype wire
